// ---- nsb_pkg.sv ----
// Package: opcodes, field widths and constants for the skip/bit/branch executor
package nsb_pkg;
   localparam int PC_W = 13;
   localparam int DA_W = 8;
   localparam int NIB_W = 4;
   localparam int NUM_REGS = 8;
   localparam int NUM_PAIRS = 8;
   localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
   localparam logic [NIB_W-1:0] NIB_ONES = 4'hf;
   localparam logic [NIB_W-1:0] NIB_ONE = 4'h1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
   localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
   // Register index map inside the 16-entry file: pair k holds regs 2k (low) and 2k+1 (high)
   localparam logic [2:0] REG_A = 3'h0;
   localparam logic [2:0] REG_X = 3'h1;
   localparam logic [2:0] REG_L = 3'h2;
   localparam logic [2:0] REG_H = 3'h3;
   // Pair index: 0..3 main bank, 4..7 alternate bank
   localparam logic [2:0] PAIR_XA = 3'h0;
   localparam logic [2:0] PAIR_HL = 3'h1;
   // Fixed-area and port-area bases for bit addressing modes
   localparam logic [7:0] FMEM_BASE = 8'hb0;
   localparam logic [7:0] PMEM_BASE = 8'hc0;
   localparam logic [7:0] RESET_NIB_SEL = 8'h00;

   typedef enum logic [5:0] {
      OP_NOP = 6'b000000,
      OP_ROTATE_RIGHT_THROUGH_CARRY = 6'b000001,
      OP_ACC_COMPLEMENT = 6'b000010,
      OP_INC_REG = 6'b000011,
      OP_INC_PAIR = 6'b000100,
      OP_INC_MEM_PTR = 6'b000101,
      OP_INC_MEM_DIR = 6'b000110,
      OP_DEC_REG = 6'b000111,
      OP_DEC_PAIR = 6'b001000,
      OP_CMP_REG_IMM = 6'b001001,
      OP_CMP_MEM_IMM = 6'b001010,
      OP_CMP_ACC_MEM = 6'b001011,
      OP_CMP_PAIR_MEM = 6'b001100,
      OP_CMP_ACC_REG = 6'b001101,
      OP_CMP_PAIR_PAIR = 6'b001110,
      OP_CARRY_SET = 6'b001111,
      OP_CARRY_CLEAR = 6'b010000,
      OP_CARRY_INVERT = 6'b010001,
      OP_CARRY_TEST = 6'b010010,
      OP_BIT_FORCE_ONE = 6'b010011,
      OP_BIT_FORCE_ZERO = 6'b010100,
      OP_SKIP_IF_BIT_TRUE = 6'b010101,
      OP_SKIP_IF_BIT_FALSE = 6'b010110,
      OP_TEST_THEN_CLEAR_BIT = 6'b010111,
      OP_CARRY_AND_BIT = 6'b011000,
      OP_CARRY_OR_BIT = 6'b011001,
      OP_CARRY_XOR_BIT = 6'b011010,
      OP_JUMP_ABSOLUTE = 6'b011011,
      OP_JUMP_RELATIVE = 6'b011100,
      OP_JUMP_WITHIN_BLOCK = 6'b011101
   } nsb_op_type;

   typedef enum logic [1:0] {
      BM_DIRECT = 2'b00,
      BM_FIXED = 2'b01,
      BM_PORT_L = 2'b10,
      BM_BANK_H = 2'b11
   } nsb_bitmode_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_READ_HI = 2'b10,
      ST_WRITE = 2'b11
   } nsb_state_type;
endpackage

// ---- nsb_bit_addr.sv ----
// Bit-addressing mode resolver: nibble address and bit number
`timescale 1ns/100ps
module nsb_bit_addr
   import nsb_pkg::*;
(
   // Mode and operands
   input  wire nsb_bitmode_type mode,
   input  wire logic [7:0]      mem_imm,
   input  wire logic [1:0]      bit_imm,
   // Pointer registers
   input  wire logic [3:0]      ptr_l,
   input  wire logic [3:0]      ptr_h,
   // Resolved location
   output      logic [7:0]      nib_addr,
   output      logic [1:0]      bit_sel
);
   // Fixed area uses the low nibble of the operand as offset
   wire [7:0] fixed_addr = FMEM_BASE | {4'h0, mem_imm[3:0]};
   // Port area: L high bits pick nibble, low two bits pick bit
   wire [7:0] port_addr = PMEM_BASE | {6'h00, ptr_l[3:2]};
   wire [7:0] bank_addr = {ptr_h, mem_imm[3:0]};

   assign nib_addr = (mode == BM_DIRECT) ? mem_imm :
                     (mode == BM_FIXED)  ? fixed_addr :
                     (mode == BM_PORT_L) ? port_addr : bank_addr;
   assign bit_sel = (mode == BM_PORT_L) ? ptr_l[1:0] : bit_imm;
endmodule // nsb_bit_addr

// ---- nsb_exec.sv ----
// Executor for rotate, skip, compare, carry, memory bit and branch instructions
`timescale 1ns/100ps
module nsb_exec
   import nsb_pkg::*;
(
   // Clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst,
   // Decoded instruction from fetch
   input  wire logic            instr_valid,
   input  wire nsb_op_type      instr_op,
   input  wire logic [2:0]      instr_reg,
   input  wire logic [2:0]      instr_pair,
   input  wire logic [3:0]      instr_imm4,
   input  wire nsb_bitmode_type instr_bitmode,
   input  wire logic [7:0]      instr_mem,
   input  wire logic [1:0]      instr_bit,
   input  wire logic [12:0]     instr_target,
   input  wire logic [4:0]      instr_rel,
   input  wire logic [1:0]      instr_len,
   output      logic            instr_ready,
   // Data memory
   output      logic            dmem_we,
   output      logic [7:0]      dmem_addr,
   output      logic [3:0]      dmem_wdata,
   input  wire logic [3:0]      dmem_rdata,
   // Architectural state
   output      logic [12:0]     pc,
   output      logic            carry_flag,
   output      logic [3:0]      acc,
   output      logic            skip_pending
);
   logic [3:0]    regs_q [NUM_PAIRS*2];
   logic [12:0]   pc_q;
   logic          cy_q, skip_q;
   nsb_state_type st_q;
   logic [3:0]    lo_q;
   logic [7:0]    addr_q;
   default clocking cb_exec @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Pair read helper, used for several operands
   function automatic logic [7:0] pair_rd(input logic [2:0] p, input logic [3:0] r [NUM_PAIRS*2]);
      pair_rd = {r[{p, 1'b1}], r[{p, 1'b0}]};
   endfunction

   wire [7:0] hl = pair_rd(PAIR_HL, regs_q);
   wire [7:0] xa = pair_rd(PAIR_XA, regs_q);
   wire [3:0] reg_v = regs_q[{1'b0, instr_reg}];
   wire [7:0] pair_v = pair_rd(instr_pair, regs_q);
   wire [3:0] reg_inc = reg_v + NIB_ONE;
   wire [3:0] reg_dec = reg_v - NIB_ONE;
   wire [7:0] pair_inc = pair_v + BYTE_ONE;
   wire [7:0] pair_dec = pair_v - BYTE_ONE;
   // pointer forced even for byte compare
   wire [7:0] hl_even = {hl[7:1], 1'b0};

   logic [7:0] bit_nib;
   logic [1:0] bit_sel;
   nsb_bit_addr u_bit_addr (
      .mode     (instr_bitmode),
      .mem_imm  (instr_mem),
      .bit_imm  (instr_bit),
      .ptr_l    (regs_q[REG_L]),
      .ptr_h    (regs_q[REG_H]),
      .nib_addr (bit_nib),
      .bit_sel  (bit_sel)
   );

   wire is_bit_op = (instr_op >= OP_BIT_FORCE_ONE) && (instr_op <= OP_CARRY_XOR_BIT);
   wire is_mem_op = is_bit_op || (instr_op == OP_INC_MEM_PTR) || (instr_op == OP_INC_MEM_DIR) ||
                    (instr_op == OP_CMP_MEM_IMM) || (instr_op == OP_CMP_ACC_MEM) ||
                    (instr_op == OP_CMP_PAIR_MEM);
   wire [7:0] mem_addr_sel = is_bit_op ? bit_nib :
                             (instr_op == OP_INC_MEM_DIR) ? instr_mem :
                             (instr_op == OP_CMP_PAIR_MEM) ? hl_even : hl;
   wire       mem_bit = dmem_rdata[bit_sel];
   wire [3:0] bit_mask = NIB_ONE << bit_sel;
   wire       take = instr_valid && (st_q == ST_IDLE);
   wire       exec = take && !skip_q;
   wire       mem_start = exec && is_mem_op;
   wire       last_mem = (st_q == ST_READ && instr_op != OP_CMP_PAIR_MEM) || (st_q == ST_READ_HI);
   wire [12:0] pc_seq = pc_q + {11'h000, instr_len};
   // Five signed bits reach +16 only when the offset counts from the next word
   // full counter relative
   wire [12:0] pc_rel = pc_q + PC_ONE + {{8{instr_rel[4]}}, instr_rel};
   wire [12:0] pc_blk = {pc_seq[12], instr_target[11:0]};

   assign instr_ready = (st_q == ST_IDLE) ? !mem_start : last_mem;
   assign pc = pc_q;
   assign carry_flag = cy_q;
   assign acc = regs_q[REG_A];
   assign skip_pending = skip_q;
   assign dmem_addr = (st_q == ST_IDLE) ? mem_addr_sel : addr_q;
   // Memory result and skip decision at the last memory cycle
   logic       mem_we_c, mem_skip_c, mem_cy_c;
   logic [3:0] mem_wd_c;
   always_comb begin
      mem_we_c = 1'b0;
      mem_wd_c = dmem_rdata;
      mem_skip_c = 1'b0;
      mem_cy_c = cy_q;
      case (instr_op)
         OP_INC_MEM_PTR, OP_INC_MEM_DIR: begin
            mem_we_c = 1'b1;
            mem_wd_c = dmem_rdata + NIB_ONE;
            mem_skip_c = (mem_wd_c == NIB_ZERO);
         end
         OP_CMP_MEM_IMM: mem_skip_c = (dmem_rdata == instr_imm4);
         OP_CMP_ACC_MEM: mem_skip_c = (dmem_rdata == regs_q[REG_A]);
         OP_CMP_PAIR_MEM: mem_skip_c = (lo_q == regs_q[REG_A]) && (dmem_rdata == regs_q[REG_X]);
         OP_BIT_FORCE_ONE: begin
            mem_we_c = 1'b1;
            mem_wd_c = dmem_rdata | bit_mask;
         end
         OP_BIT_FORCE_ZERO: begin
            mem_we_c = 1'b1;
            mem_wd_c = dmem_rdata & ~bit_mask;
         end
         OP_SKIP_IF_BIT_TRUE: mem_skip_c = mem_bit;
         OP_SKIP_IF_BIT_FALSE: mem_skip_c = !mem_bit;
         OP_TEST_THEN_CLEAR_BIT: begin
            mem_skip_c = mem_bit;
            mem_we_c = mem_bit;
            mem_wd_c = dmem_rdata & ~bit_mask;
         end
         OP_CARRY_AND_BIT: mem_cy_c = cy_q & mem_bit;
         OP_CARRY_OR_BIT: mem_cy_c = cy_q | mem_bit;
         OP_CARRY_XOR_BIT: mem_cy_c = cy_q ^ mem_bit;
         default: mem_skip_c = 1'b0;
      endcase
   end

   assign dmem_we = (st_q == ST_WRITE);
   assign dmem_wdata = lo_q;
   // Register-only result, carry and skip in the issue cycle
   logic        rg_we_c, pr_we_c, rg_skip_c, rg_cy_c;
   logic [3:0]  rg_wd_c;
   logic [7:0]  pr_wd_c;
   logic [12:0] pc_c;
   always_comb begin
      rg_we_c = 1'b0;
      rg_wd_c = reg_v;
      pr_we_c = 1'b0;
      pr_wd_c = pair_v;
      rg_skip_c = 1'b0;
      rg_cy_c = cy_q;
      pc_c = pc_seq;
      case (instr_op)
         OP_ROTATE_RIGHT_THROUGH_CARRY: begin
            rg_cy_c = regs_q[REG_A][0];
            rg_we_c = 1'b1;
            rg_wd_c = {cy_q, regs_q[REG_A][3:1]};
         end
         OP_ACC_COMPLEMENT: begin
            rg_we_c = 1'b1;
            rg_wd_c = ~regs_q[REG_A];
         end
         OP_INC_REG: begin
            rg_we_c = 1'b1;
            rg_wd_c = reg_inc;
            rg_skip_c = (reg_inc == NIB_ZERO);
         end
         OP_INC_PAIR: begin
            pr_we_c = 1'b1;
            pr_wd_c = pair_inc;
            rg_skip_c = (pair_inc == BYTE_ZERO);
         end
         OP_DEC_REG: begin
            rg_we_c = 1'b1;
            rg_wd_c = reg_dec;
            rg_skip_c = (reg_dec == NIB_ONES);
         end
         OP_DEC_PAIR: begin
            pr_we_c = 1'b1;
            pr_wd_c = pair_dec;
            rg_skip_c = (pair_dec == BYTE_ONES);
         end
         OP_CMP_REG_IMM: rg_skip_c = (reg_v == instr_imm4);
         OP_CMP_ACC_REG: rg_skip_c = (regs_q[REG_A] == reg_v);
         OP_CMP_PAIR_PAIR: rg_skip_c = (xa == pair_v);
         OP_CARRY_SET: rg_cy_c = 1'b1;
         OP_CARRY_CLEAR: rg_cy_c = 1'b0;
         OP_CARRY_INVERT: rg_cy_c = ~cy_q;
         OP_CARRY_TEST: rg_skip_c = cy_q;
         OP_JUMP_ABSOLUTE: pc_c = instr_target;
         OP_JUMP_RELATIVE: pc_c = pc_rel;
         OP_JUMP_WITHIN_BLOCK: pc_c = pc_blk;
         default: rg_skip_c = 1'b0;
      endcase
   end

   // Rotate and complement target A; others target the named register
   wire [2:0] rg_idx = ((instr_op == OP_ROTATE_RIGHT_THROUGH_CARRY) || (instr_op == OP_ACC_COMPLEMENT)) ?
                       REG_A : instr_reg;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_q <= ST_IDLE;
         pc_q <= PC_RESET;
         cy_q <= 1'b0;
         skip_q <= 1'b0;
         lo_q <= NIB_ZERO;
         addr_q <= RESET_NIB_SEL;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (take && skip_q) begin
                  pc_q <= pc_seq;
                  skip_q <= 1'b0;
               end else if (mem_start) begin
                  st_q <= ST_READ;
                  addr_q <= mem_addr_sel;
               end else if (exec) begin
                  pc_q <= pc_c;
                  cy_q <= rg_cy_c;
                  skip_q <= rg_skip_c;
               end
            end
            ST_READ: begin
               if (instr_op == OP_CMP_PAIR_MEM) begin
                  lo_q <= dmem_rdata;
                  addr_q <= addr_q + BYTE_ONE;
                  st_q <= ST_READ_HI;
               end else begin
                  pc_q <= pc_seq;
                  cy_q <= mem_cy_c;
                  skip_q <= mem_skip_c;
                  lo_q <= mem_wd_c;
                  st_q <= mem_we_c ? ST_WRITE : ST_IDLE;
               end
            end
            ST_READ_HI: begin
               pc_q <= pc_seq;
               skip_q <= mem_skip_c;
               st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // Register file, one write port
   for (genvar gi = 0; gi < NUM_PAIRS*2; gi++) begin : g_regs
      always_ff @(posedge ref_clk) begin
         if (rst) begin
            regs_q[gi] <= NIB_ZERO;
         end else if (exec && !is_mem_op && rg_we_c && (gi == {1'b0, rg_idx})) begin
            regs_q[gi] <= rg_wd_c;
         end else if (exec && !is_mem_op && pr_we_c && ((gi >> 1) == instr_pair)) begin
            regs_q[gi] <= (gi % 2 == 1) ? pr_wd_c[7:4] : pr_wd_c[3:0];
         end
      end
   end
   property p_rotate;
      exec && instr_op == OP_ROTATE_RIGHT_THROUGH_CARRY |=> cy_q == $past(regs_q[REG_A][0]) && acc[3] == $past(cy_q);
   endproperty
   a_rotate: assert property (p_rotate) else $error("rotate wrong");
   property p_inc_skip;
      exec && instr_op == OP_INC_REG && reg_v == NIB_ONES |=> skip_q;
   endproperty
   a_inc_skip: assert property (p_inc_skip) else $error("inc skip missing");
   property p_dec_skip;
      exec && instr_op == OP_DEC_REG |=> skip_q == ($past(reg_v) == NIB_ZERO);
   endproperty
   a_dec_skip: assert property (p_dec_skip) else $error("dec skip wrong");
   property p_skip_no_effect;
      take && skip_q |=> !skip_q && $stable(cy_q) && st_q == ST_IDLE;
   endproperty
   a_skip_no_effect: assert property (p_skip_no_effect) else $error("skipped op had effect");
   property p_abs;
      exec && instr_op == OP_JUMP_ABSOLUTE |=> pc_q == $past(instr_target);
   endproperty
   a_abs: assert property (p_abs) else $error("absolute jump wrong");
   property p_blk;
      exec && instr_op == OP_JUMP_WITHIN_BLOCK |=> pc_q[11:0] == $past(instr_target[11:0]);
   endproperty
   a_blk: assert property (p_blk) else $error("block jump wrong");
   property p_cy_keep;
      exec && (instr_op == OP_INC_REG || instr_op == OP_CMP_REG_IMM) |=> $stable(cy_q);
   endproperty
   a_cy_keep: assert property (p_cy_keep) else $error("carry disturbed");
   // Fields already belong to the next instruction in the write cycle, so the mask is taken one edge back
   sequence s_clr_issue;
      mem_start && instr_op == OP_BIT_FORCE_ZERO;
   endsequence
   property p_clr_write;
      s_clr_issue ##1 1'b1 |=> dmem_we && (dmem_wdata & $past(bit_mask)) == NIB_ZERO;
   endproperty
   a_clr_write: assert property (p_clr_write) else $error("bit clear write wrong");
   property p_cy_test;
      exec && instr_op == OP_CARRY_TEST |=> skip_q == $past(cy_q);
   endproperty
   a_cy_test: assert property (p_cy_test) else $error("carry test wrong");
endmodule // nsb_exec

// ---- nsb_dmem_model.sv ----
// Data memory partner: 256 nibbles, same-cycle read, write on the clock edge
`timescale 1ns/100ps
module nsb_dmem_model (
   // Clock
   ref_clk,
   // Access from the executor
   dmem_we,
   dmem_addr,
   dmem_wdata,
   dmem_rdata
);
   input  wire logic       ref_clk;
   input  wire logic       dmem_we;
   input  wire logic [7:0] dmem_addr;
   input  wire logic [3:0] dmem_wdata;
   output      logic [3:0] dmem_rdata;

   logic [3:0] mem_q [256];

   // No read latency: the executor uses read data in the cycle it drives the address
   assign dmem_rdata = mem_q[dmem_addr];

   always @(posedge ref_clk) begin
      if (dmem_we) begin
         mem_q[dmem_addr] <= dmem_wdata;
      end
   end
endmodule // nsb_dmem_model

// ---- nsb_exec_tb.sv ----
// Self-checking bench for the skip, bit and branch executor
`timescale 1ns/100ps
module nsb_exec_tb;
   import nsb_pkg::*;
   logic            ref_clk     = 1'b0;
   logic            rst         = 1'b1;
   logic            instr_valid = 1'b0;
   nsb_op_type      op          = OP_NOP;
   logic [2:0]      f_reg       = 3'h0;
   logic [2:0]      f_pair      = 3'h0;
   logic [3:0]      f_imm       = 4'h0;
   nsb_bitmode_type f_mode      = BM_DIRECT;
   logic [7:0]      f_mem       = 8'h00;
   logic [1:0]      f_bit       = 2'h0;
   logic [12:0]     f_tgt       = 13'h0000;
   logic [4:0]      f_rel       = 5'h00;
   logic [1:0]      f_len       = 2'h1;
   logic            instr_ready, dmem_we, carry_flag, skip_pending;
   logic [7:0]      dmem_addr;
   logic [3:0]      dmem_wdata, dmem_rdata, acc;
   logic [12:0]     pc;
   int              n_errors    = 0;
   int              checked     = 0;
   int              seed        = 32'h260e4771;
   logic [3:0]      m_reg [16];
   logic [3:0]      m_mem [256];
   logic [12:0]     m_pc;
   logic            m_cy, m_skip;
   logic [12:0]     starts [4] = '{13'h0ffe, 13'h0fff, 13'h0ffd, 13'h1ffe};
   logic [12:0]     rstart [3] = '{13'h0ffa, 13'h1003, 13'h00fe};
   // Offset field counts from the next word: these give +16, -15 and +2
   logic [4:0]      rels [3]   = '{5'h0f, 5'h10, 5'h01};

   nsb_exec dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr_op(op), .instr_reg(f_reg),
      .instr_pair(f_pair), .instr_imm4(f_imm), .instr_bitmode(f_mode), .instr_mem(f_mem), .instr_bit(f_bit),
      .instr_target(f_tgt), .instr_rel(f_rel), .instr_len(f_len), .instr_ready(instr_ready), .dmem_we(dmem_we),
      .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .pc(pc), .carry_flag(carry_flag),
      .acc(acc), .skip_pending(skip_pending));

   nsb_dmem_model mem_model (.ref_clk(ref_clk), .dmem_we(dmem_we), .dmem_addr(dmem_addr),
      .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata));

   always #5 ref_clk = ~ref_clk;

   task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("TB: %0d checks, %0d mismatches", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Reference behaviour of one consumed instruction
   task automatic model_step();
      int         p;
      logic [7:0] hl, a, pr;
      logic [1:0] bs;
      logic       b, sk;
      logic [12:0] nx;
      p = 2 * int'(f_pair);
      hl = {m_reg[3], m_reg[2]};
      pr = {m_reg[p+1], m_reg[p]};
      nx = m_pc + 13'(f_len);
      sk = 1'b0;
      a = (f_mode == BM_DIRECT) ? f_mem : (f_mode == BM_FIXED) ? FMEM_BASE + 8'(f_mem[3:0]) :
          (f_mode == BM_PORT_L) ? PMEM_BASE + 8'(m_reg[2][3:2]) : {m_reg[3], f_mem[3:0]};
      bs = (f_mode == BM_PORT_L) ? m_reg[2][1:0] : f_bit;
      b = m_mem[a][bs];
      if (!m_skip) begin
         case (op)
            OP_ROTATE_RIGHT_THROUGH_CARRY: {m_reg[0], m_cy} = {m_cy, m_reg[0]};
            OP_ACC_COMPLEMENT: m_reg[0] = ~m_reg[0];
            OP_INC_REG: begin m_reg[f_reg] = m_reg[f_reg] + 4'h1; sk = (m_reg[f_reg] == 4'h0); end
            OP_INC_PAIR: begin pr = pr + 8'h01; {m_reg[p+1], m_reg[p]} = pr; sk = (pr == 8'h00); end
            OP_INC_MEM_PTR: begin m_mem[hl] = m_mem[hl] + 4'h1; sk = (m_mem[hl] == 4'h0); end
            OP_INC_MEM_DIR: begin m_mem[f_mem] = m_mem[f_mem] + 4'h1; sk = (m_mem[f_mem] == 4'h0); end
            OP_DEC_REG: begin m_reg[f_reg] = m_reg[f_reg] - 4'h1; sk = (m_reg[f_reg] == 4'hf); end
            OP_DEC_PAIR: begin pr = pr - 8'h01; {m_reg[p+1], m_reg[p]} = pr; sk = (pr == 8'hff); end
            OP_CMP_REG_IMM: sk = (m_reg[f_reg] == f_imm);
            OP_CMP_MEM_IMM: sk = (m_mem[hl] == f_imm);
            OP_CMP_ACC_MEM: sk = (m_reg[0] == m_mem[hl]);
            OP_CMP_PAIR_MEM: sk = (m_reg[0] == m_mem[{hl[7:1], 1'b0}]) && (m_reg[1] == m_mem[{hl[7:1], 1'b1}]);
            OP_CMP_ACC_REG: sk = (m_reg[0] == m_reg[f_reg]);
            OP_CMP_PAIR_PAIR: sk = ({m_reg[1], m_reg[0]} == pr);
            OP_CARRY_SET: m_cy = 1'b1;
            OP_CARRY_CLEAR: m_cy = 1'b0;
            OP_CARRY_INVERT: m_cy = ~m_cy;
            OP_CARRY_TEST: sk = m_cy;
            OP_BIT_FORCE_ONE: m_mem[a][bs] = 1'b1;
            OP_BIT_FORCE_ZERO: m_mem[a][bs] = 1'b0;
            OP_SKIP_IF_BIT_TRUE: sk = b;
            OP_SKIP_IF_BIT_FALSE: sk = ~b;
            OP_TEST_THEN_CLEAR_BIT: begin sk = b; m_mem[a][bs] = 1'b0; end
            OP_CARRY_AND_BIT: m_cy = m_cy & b;
            OP_CARRY_OR_BIT: m_cy = m_cy | b;
            OP_CARRY_XOR_BIT: m_cy = m_cy ^ b;
            OP_JUMP_ABSOLUTE: nx = f_tgt;
            OP_JUMP_RELATIVE: nx = m_pc + 13'($signed(f_rel) + 1);
            OP_JUMP_WITHIN_BLOCK: nx = {nx[12], f_tgt[11:0]};
            default: ;
         endcase
      end
      m_pc = nx;
      m_skip = sk;
   endtask

   // Fields are set at a falling edge; held until the edge that consumes them
   task automatic run_instr();
      int k;
      instr_valid = 1'b1;
      model_step();
      #1;
      for (k = 0; k < 8 && instr_ready !== 1'b1; k++) begin
         @(negedge ref_clk);
         #1;
      end
      if (k == 8) begin
         n_errors++;
         $display("ERROR %0t: instruction never taken", $time);
      end
      @(negedge ref_clk);
      check(pc, m_pc, "pc");
      check(13'(carry_flag), 13'(m_cy), "carry");
      check(13'(acc), 13'(m_reg[0]), "accumulator");
      check(13'(skip_pending), 13'(m_skip), "skip");
   endtask

   task automatic set_op(input nsb_op_type o, input logic [12:0] t, input logic [4:0] r, input logic [1:0] l);
      op = o;
      f_tgt = t;
      f_rel = r;
      f_len = l;
   endtask

   task automatic mem_check();
      instr_valid = 1'b0;
      repeat (3) @(negedge ref_clk);
      for (int i = 0; i < 256; i++) begin
         check(13'(mem_model.mem_q[i]), 13'(m_mem[i]), "memory nibble");
      end
   endtask

   task automatic rand_instr();
      int rv;
      op = nsb_op_type'(6'(1 + (($random(seed) & 32'h7fff) % 29)));
      f_reg = 3'($random(seed));
      f_pair = (op == OP_INC_PAIR) ? 3'(1 + (($random(seed) & 32'hff) % 3)) : 3'($random(seed));
      f_imm = 4'($random(seed));
      f_mem = 8'($random(seed));
      f_bit = 2'($random(seed));
      f_mode = nsb_bitmode_type'(2'($random(seed)));
      // Test-and-clear and carry logic have no direct addressing form
      if (op >= OP_TEST_THEN_CLEAR_BIT && op <= OP_CARRY_XOR_BIT && f_mode == BM_DIRECT) f_mode = BM_BANK_H;
      f_tgt = 13'($random(seed));
      f_len = 2'(1 + (($random(seed) & 32'h7fff) % 3));
      // Displacements -15..-1 and +2..+16, encoded as displacement minus one
      rv = ($random(seed) & 32'hff) % 30;
      f_rel = 5'((rv < 15) ? rv - 16 : rv - 14);
      run_instr();
   endtask

   initial begin
      #500000;
      n_errors++;
      $display("ERROR %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      for (int i = 0; i < 256; i++) begin
         m_mem[i] = 4'($random(seed));
         mem_model.mem_q[i] = m_mem[i];
      end
      foreach (m_reg[i]) m_reg[i] = 4'h0;
      m_pc = PC_RESET;
      m_cy = 1'b0;
      m_skip = 1'b0;
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      @(negedge ref_clk);
      check(pc, m_pc, "reset pc");
      check(13'({carry_flag, skip_pending, acc}), 13'h0000, "reset state");
      $display("TB: reset test done");
      foreach (starts[i]) begin
         set_op(OP_NOP, 13'h0000, 5'h00, 2'h1);
         run_instr();
         run_instr();
         set_op(OP_JUMP_ABSOLUTE, starts[i], 5'h00, 2'h2);
         run_instr();
         set_op(OP_JUMP_WITHIN_BLOCK, 13'h0234, 5'h00, 2'h2);
         run_instr();
      end
      $display("TB: block jump test done");
      foreach (rstart[i]) begin
         set_op(OP_JUMP_ABSOLUTE, rstart[i], 5'h00, 2'h2);
         run_instr();
         set_op(OP_JUMP_RELATIVE, 13'h0000, rels[i], 2'h1);
         run_instr();
      end
      $display("TB: relative jump test done");
      repeat (700) rand_instr();
      mem_check();
      $display("TB: random instruction test done");
      finish_test();
   end
endmodule // nsb_exec_tb
